// *** verilog/nvsp_pkg.sv ***
`default_nettype none
package nvsp_pkg;

  // bus widths and array geometry
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int N_FLASH   = 8;
  localparam int N_EE      = 4;
  localparam int SRAM_AW   = 11;
  localparam int SRAM_WORDS = 2048;

  // command codes written on the data bus
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE   = 8'h80;
  localparam logic [7:0] CMD_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_RESUME  = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESET   = 8'hf0;

  // address map of the decode logic array
  localparam logic [7:0] CTRL_PAGE     = 8'he0;
  localparam logic [1:0] FLASH_WIN     = 2'b10;
  localparam logic       EE_WIN        = 1'b0;
  localparam logic [4:0] SRAM_PT0      = 5'b11000;
  localparam logic [4:0] SRAM_PT1      = 5'b11010;
  localparam logic [7:0] SRAM_PT1_PAGE = 8'h00;

  // control register space offsets and fields
  localparam logic [7:0] FLASH_LOCK_OFS = 8'hc0;
  localparam logic [7:0] EE_LOCK_OFS    = 8'hc2;
  localparam int         EE_SECURE_BIT  = 7;
  localparam logic [7:0] FLASH_PROT_RST = 8'h00;
  localparam logic [3:0] EE_PROT_RST    = 4'h0;
  localparam logic [7:0] RDATA_RST      = 8'h00;

  // reset command settle time
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_TIME_NS = 1000000;
  localparam int RESET_CYCLES  = RESET_TIME_NS / CLK_PERIOD_NS;
  localparam int RST_CNT_W     = 17;

  // operations handed to the array engine
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_ERASE   = 3'h2,
    OP_SUSPEND = 3'h3,
    OP_RESUME  = 3'h4,
    OP_ABORT   = 3'h5
  } nvsp_op_e;

  // command state machine
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_UNL1  = 10'h002,
    ST_UNL2  = 10'h004,
    ST_PROG  = 10'h008,
    ST_ERS1  = 10'h010,
    ST_ERS2  = 10'h020,
    ST_ERS3  = 10'h040,
    ST_ERASE = 10'h080,
    ST_SUSP  = 10'h100,
    ST_RSTW  = 10'h200
  } nvsp_state_e;

endpackage
`default_nettype wire

// *** verilog/nvsp_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface nvsp_bus_if;
  import nvsp_pkg::*;
  logic [ADDR_W-1:0]  addr;
  logic [7:0]         page;
  logic [DATA_W-1:0]  wdata;
  logic               wr;
  logic [N_FLASH-1:0] flash_sel;
  logic [N_EE-1:0]    ee_sel;
  logic               sram_sel;
  logic               ctrl_sel;
  logic [DATA_W-1:0]  sram_rdata;

  modport core (output addr, page, wdata, wr,
                input  flash_sel, ee_sel, sram_sel, ctrl_sel, sram_rdata);
  modport dec  (input  addr, page, output flash_sel, ee_sel, sram_sel, ctrl_sel);
  modport sram (input  addr, wdata, wr, sram_sel, output sram_rdata);
endinterface
`default_nettype wire

// *** verilog/nvsp_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvsp_decode
  import nvsp_pkg::*;
(
  nvsp_bus_if.dec bus
);

  // flash sectors share one 16K window and are picked by the page register
  always_comb begin
    for (int i = 0; i < N_FLASH; i++) begin
      bus.flash_sel[i] = (bus.addr[15:14] == FLASH_WIN) && (bus.page[2:0] == 3'(i));
    end
  end

  // eeprom sectors tile the low half, 8K each, never overlapping
  always_comb begin
    for (int j = 0; j < N_EE; j++) begin
      bus.ee_sel[j] = (bus.addr[15] == EE_WIN) && (bus.addr[14:13] == 2'(j));
    end
  end

  // sram select is the sum of two product terms only
  assign bus.sram_sel = (bus.addr[15:11] == SRAM_PT0)
                      | ((bus.addr[15:11] == SRAM_PT1) && (bus.page == SRAM_PT1_PAGE));

  // control register space occupies one 256-byte page
  assign bus.ctrl_sel = (bus.addr[15:8] == CTRL_PAGE);

endmodule
`default_nettype wire

// *** verilog/nvsp_sram.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvsp_sram
  import nvsp_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_ce,
  nvsp_bus_if.sram  bus
);

  logic [DATA_W-1:0] mem [0:SRAM_WORDS-1];

  // write port, enabled by the clock enable, the write strobe and the sram select together
  always_ff @(posedge i_clk) begin
    if (i_ce && bus.wr && bus.sram_sel) begin
      mem[bus.addr[SRAM_AW-1:0]] <= bus.wdata;
    end
  end

  // read data, forced to zero when not selected
  assign bus.sram_rdata = bus.sram_sel ? mem[bus.addr[SRAM_AW-1:0]] : '0;

endmodule
`default_nettype wire

// *** verilog/nvsp_top.sv ***
// Operation
// - 30h with flash selected resumes suspended erase
// - resume acts only after an accepted suspend
// - each flash and eeprom sector has lock
// - locks change only via test port
// - host writes never alter lock bits
// - program and erase to locked sectors silently dropped
// - reads of locked sectors return stored data
// - flash lock register: bit i, sector i
// - eeprom lock bits 3..0, bits 6..4 unused
// - eeprom lock register bit 7 is security
// - both lock registers readable in control space
// - reset accepted as one or three writes
// - reset returns command machine to idle
// - 2K x 8 sram answers only when selected
// - sram select uses at most two terms
// - battery pin high while supply below battery and battery feeds sram
// - b0h with flash selected suspends erase
// - while suspended only resume and reset accepted
// - eeprom wins over flash on overlap
`timescale 1ns/100ps
`default_nettype none
module nvsp_top
  import nvsp_pkg::*;
#(
  parameter int P_RESET_CYCLES = RESET_CYCLES
)(
  input  wire logic               i_clk,
  input  wire logic               i_reset,
  input  wire logic               i_ce,
  // host bus, synchronous strobes
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]         i_page,
  input  wire logic [DATA_W-1:0]  i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [DATA_W-1:0]       o_rdata,
  output logic                    o_rdata_valid,
  // array read data and engine handshake
  input  wire logic [DATA_W-1:0]  i_array_rdata,
  input  wire logic               i_nv_done,
  output logic                    o_nv_cmd,
  output nvsp_op_e                o_nv_op,
  output logic [ADDR_W-1:0]       o_nv_addr,
  output logic [DATA_W-1:0]       o_nv_wdata,
  output logic                    o_nv_to_ee,
  output logic [N_FLASH-1:0]      o_nv_sector_mask,
  output logic                    o_erase_suspended,
  output logic                    o_cmd_idle,
  // test port / programmer lock load
  input  wire logic               i_tap_lock_load,
  input  wire logic [N_FLASH-1:0] i_tap_flash_lock,
  input  wire logic [N_EE-1:0]    i_tap_ee_lock,
  input  wire logic               i_tap_secure,
  // sram and battery indication
  output logic                    o_sram_select,
  input  wire logic               i_batt_pin_is_output,
  input  wire logic               i_supply_below_batt,
  input  wire logic               i_batt_feeds_sram,
  output logic                    o_batt_active,
  output logic                    o_batt_active_oe
);

  typedef struct packed {
    nvsp_state_e          st;
    logic                 susp;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [N_FLASH-1:0]   flash_lock;
    logic [N_EE-1:0]      ee_lock;
    logic                 secure;
    logic [DATA_W-1:0]    rdata;
    logic                 rvalid;
    logic                 cmd;
    nvsp_op_e             op;
    logic [ADDR_W-1:0]    nv_addr;
    logic [DATA_W-1:0]    nv_wdata;
    logic                 nv_ee;
    logic [N_FLASH-1:0]   nv_mask;
    logic                 batt;
  } nvsp_core_s;

  localparam nvsp_core_s CORE_RST = '{
    st:         ST_IDLE,
    susp:       1'b0,
    rst_cnt:    '0,
    flash_lock: FLASH_PROT_RST,
    ee_lock:    EE_PROT_RST,
    secure:     1'b0,
    rdata:      RDATA_RST,
    rvalid:     1'b0,
    cmd:        1'b0,
    op:         OP_NONE,
    nv_addr:    '0,
    nv_wdata:   '0,
    nv_ee:      1'b0,
    nv_mask:    '0,
    batt:       1'b0
  };

  nvsp_core_s core_r;
  nvsp_core_s core_nxt;

  nvsp_bus_if bus ();

  // true when the addressed sector is locked; eeprom takes priority
  function automatic logic sector_locked(input logic [N_FLASH-1:0] fsel,
                                         input logic [N_EE-1:0]    esel,
                                         input logic [N_FLASH-1:0] flock,
                                         input logic [N_EE-1:0]    elock);
    if (|esel) begin
      sector_locked = |(esel & elock);
    end else begin
      sector_locked = |(fsel & flock);
    end
  endfunction

  // sector mask sent to the engine for the addressed sector
  function automatic logic [N_FLASH-1:0] sector_mask(input logic [N_FLASH-1:0] fsel,
                                                     input logic [N_EE-1:0]    esel);
    if (|esel) begin
      sector_mask = {{(N_FLASH-N_EE){1'b0}}, esel};
    end else begin
      sector_mask = fsel;
    end
  endfunction

  // host bus onto the internal carrier
  assign bus.addr  = i_addr;
  assign bus.page  = i_page;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr;

  nvsp_decode u_decode (
    .bus (bus)
  );

  nvsp_sram u_sram (
    .i_clk (i_clk),
    .i_ce  (i_ce),
    .bus   (bus)
  );

  // decoded access classes, sram and control space shadow the arrays
  logic mem_hit;
  logic flash_hit;
  logic mem_wr;
  logic locked;

  assign mem_hit   = ~bus.ctrl_sel & ~bus.sram_sel & ((|bus.flash_sel) | (|bus.ee_sel));
  assign flash_hit = ~bus.ctrl_sel & ~bus.sram_sel & (|bus.flash_sel);
  assign mem_wr    = i_wr & mem_hit;
  assign locked    = sector_locked(bus.flash_sel, bus.ee_sel, core_r.flash_lock, core_r.ee_lock);

  // next-state logic of the whole block
  always_comb begin
    core_nxt        = core_r;
    core_nxt.cmd    = 1'b0;
    core_nxt.op     = OP_NONE;
    core_nxt.rvalid = 1'b0;

    // battery indicator only when the pin is an output
    core_nxt.batt = i_batt_pin_is_output & i_supply_below_batt & i_batt_feeds_sram;

    // locks are loaded only from the test port
    if (i_tap_lock_load) begin
      core_nxt.flash_lock = i_tap_flash_lock;
      core_nxt.ee_lock    = i_tap_ee_lock;
      core_nxt.secure     = i_tap_secure;
    end

    // read path: control registers, sram, then the arrays
    if (i_rd) begin
      core_nxt.rvalid = 1'b1;
      if (bus.ctrl_sel) begin
        unique case (i_addr[7:0])
          FLASH_LOCK_OFS: core_nxt.rdata = core_r.flash_lock;
          EE_LOCK_OFS:    core_nxt.rdata = {core_r.secure, 3'h0, core_r.ee_lock};
          default:        core_nxt.rdata = '0;
        endcase
      end else if (bus.sram_sel) begin
        core_nxt.rdata = bus.sram_rdata;
      end else begin
        core_nxt.rdata = i_array_rdata;
      end
    end

    // command state machine, fed by writes that hit an array, the engine done and the reset wait counter
    unique case (core_r.st)
      ST_IDLE: begin
        if (mem_wr) begin
          if (i_wdata == CMD_UNLOCK1) begin
            core_nxt.st = ST_UNL1;
          end else if (i_wdata == CMD_RESET) begin
            core_nxt.st = ST_RSTW;
          end else begin
            core_nxt.st = ST_IDLE;
          end
        end
      end
      ST_UNL1: begin
        if (mem_wr) begin
          if (i_wdata == CMD_UNLOCK2) begin
            core_nxt.st = ST_UNL2;
          end else begin
            core_nxt.st = core_r.susp ? ST_SUSP : ST_IDLE;
          end
        end
      end
      ST_UNL2: begin
        if (mem_wr) begin
          if (i_wdata == CMD_RESET) begin
            core_nxt.st = ST_RSTW;
          end else if (core_r.susp) begin
            core_nxt.st = ST_SUSP;
          end else if (i_wdata == CMD_PROGRAM) begin
            core_nxt.st = ST_PROG;
          end else if (i_wdata == CMD_ERASE) begin
            core_nxt.st = ST_ERS1;
          end else begin
            core_nxt.st = ST_IDLE;
          end
        end
      end
      ST_PROG: begin
        if (mem_wr) begin
          core_nxt.st = ST_IDLE;
          if (!locked) begin
            core_nxt.cmd      = 1'b1;
            core_nxt.op       = OP_PROGRAM;
            core_nxt.nv_addr  = i_addr;
            core_nxt.nv_wdata = i_wdata;
            core_nxt.nv_ee    = |bus.ee_sel;
            core_nxt.nv_mask  = sector_mask(bus.flash_sel, bus.ee_sel);
          end
        end
      end
      ST_ERS1: begin
        if (mem_wr) begin
          core_nxt.st = (i_wdata == CMD_UNLOCK1) ? ST_ERS2 : ST_IDLE;
        end
      end
      ST_ERS2: begin
        if (mem_wr) begin
          core_nxt.st = (i_wdata == CMD_UNLOCK2) ? ST_ERS3 : ST_IDLE;
        end
      end
      ST_ERS3: begin
        if (mem_wr) begin
          core_nxt.st = ST_IDLE;
          if (i_wdata == CMD_CONFIRM && !locked) begin
            core_nxt.st       = ST_ERASE;
            core_nxt.cmd      = 1'b1;
            core_nxt.op       = OP_ERASE;
            core_nxt.nv_addr  = i_addr;
            core_nxt.nv_wdata = i_wdata;
            core_nxt.nv_ee    = |bus.ee_sel;
            core_nxt.nv_mask  = sector_mask(bus.flash_sel, bus.ee_sel);
          end
        end
      end
      ST_ERASE: begin
        if (mem_wr && flash_hit && i_wdata == CMD_SUSPEND) begin
          core_nxt.st   = ST_SUSP;
          core_nxt.susp = 1'b1;
          core_nxt.cmd  = 1'b1;
          core_nxt.op   = OP_SUSPEND;
        end else if (mem_wr && i_wdata == CMD_RESET) begin
          core_nxt.st = ST_RSTW;
        end else if (i_nv_done) begin
          core_nxt.st = ST_IDLE;
        end
      end
      ST_SUSP: begin
        if (mem_wr) begin
          if (flash_hit && i_wdata == CMD_RESUME && core_r.susp) begin
            core_nxt.st   = ST_ERASE;
            core_nxt.susp = 1'b0;
            core_nxt.cmd  = 1'b1;
            core_nxt.op   = OP_RESUME;
          end else if (i_wdata == CMD_RESET) begin
            core_nxt.st = ST_RSTW;
          end else if (i_wdata == CMD_UNLOCK1) begin
            core_nxt.st = ST_UNL1;
          end else begin
            core_nxt.st = ST_SUSP;
          end
        end
      end
      ST_RSTW: begin
        if (core_r.rst_cnt == RST_CNT_W'(P_RESET_CYCLES - 1)) begin
          core_nxt.st      = ST_IDLE;
          core_nxt.rst_cnt = '0;
        end else begin
          core_nxt.rst_cnt = core_r.rst_cnt + RST_CNT_W'(1);
        end
      end
      default: begin
        core_nxt.st = ST_IDLE;
      end
    endcase

    // entry into the reset wait aborts the engine and clears suspend
    if (core_nxt.st == ST_RSTW && core_r.st != ST_RSTW) begin
      core_nxt.cmd     = 1'b1;
      core_nxt.op      = OP_ABORT;
      core_nxt.susp    = 1'b0;
      core_nxt.rst_cnt = '0;
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      core_r <= CORE_RST;
    end else if (i_ce) begin
      core_r <= core_nxt;
    end
  end

  // outputs straight from the state register, except battery pin enable and sram select taken from the inputs
  assign o_rdata           = core_r.rdata;
  assign o_rdata_valid     = core_r.rvalid;
  assign o_nv_cmd          = core_r.cmd;
  assign o_nv_op           = core_r.op;
  assign o_nv_addr         = core_r.nv_addr;
  assign o_nv_wdata        = core_r.nv_wdata;
  assign o_nv_to_ee        = core_r.nv_ee;
  assign o_nv_sector_mask  = core_r.nv_mask;
  assign o_erase_suspended = core_r.susp;
  assign o_cmd_idle        = (core_r.st == ST_IDLE);
  assign o_batt_active     = core_r.batt;
  assign o_batt_active_oe  = i_batt_pin_is_output;  // pin drives only when set as output
  assign o_sram_select     = bus.sram_sel;

endmodule
`default_nettype wire

// *** verif/nvsp_top_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvsp_top_assertions
  import nvsp_pkg::*;
#(
  parameter int P_RESET_CYCLES = 8
)(
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic       i_ce,
  input wire logic       i_rd,
  input wire logic       o_rdata_valid,
  input wire logic       o_nv_cmd,
  input var  nvsp_op_e   o_nv_op,
  input wire logic [7:0] o_nv_sector_mask,
  input wire logic       o_erase_suspended,
  input wire logic       o_cmd_idle,
  input wire logic       i_batt_pin_is_output,
  input wire logic       i_supply_below_batt,
  input wire logic       i_batt_feeds_sram,
  input wire logic       o_batt_active,
  input wire logic       o_batt_active_oe
);
  localparam int RST_BOUND = P_RESET_CYCLES + 4;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // one command pulse of a given kind
  sequence s_go(nvsp_op_e op);
    o_nv_cmd && o_nv_op == op;
  endsequence
  sequence s_write_op;
    o_nv_cmd && o_nv_op inside {OP_PROGRAM, OP_ERASE};
  endsequence
  // register reads answer exactly one cycle later
  a_read_answer: assert property (i_ce && i_rd |=> o_rdata_valid)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (o_rdata_valid |-> $past(i_rd))
    else $error("read valid without a read");
  // battery indicator follows the three conditions one cycle late
  a_batt_follows:
    assert property (!$past(i_reset) && $past(i_ce) |-> o_batt_active ==
      $past(i_batt_pin_is_output & i_supply_below_batt & i_batt_feeds_sram))
    else $error("battery indicator wrong");
  a_batt_enable: assert property (o_batt_active_oe == i_batt_pin_is_output)
    else $error("battery pin enable wrong");
  // suspend, resume and reset commands, and the sector mask of program and erase
  a_suspend_flag: assert property (s_go(OP_SUSPEND) |-> o_erase_suspended)
    else $error("suspend did not set flag");
  a_resume_cause: assert property (s_go(OP_RESUME) |-> $past(o_erase_suspended))
    else $error("resume without suspended erase");
  a_susp_blocks:
    assert property (s_write_op |-> !$past(o_erase_suspended))
    else $error("program or erase while suspended");
  a_abort_busy: assert property (s_go(OP_ABORT) |-> !o_cmd_idle)
    else $error("idle during reset command");
  a_abort_settle: assert property (s_go(OP_ABORT) |-> ##[1:RST_BOUND] o_cmd_idle)
    else $error("reset command never settled");
  a_mask_onehot: assert property (s_write_op |-> $onehot(o_nv_sector_mask))
    else $error("sector mask not one-hot");
endmodule
`default_nettype wire

// *** verif/nvsp_engine_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module nvsp_engine_model
  import nvsp_pkg::*;
#(
  parameter int P_ERASE_CYCLES = 40
)(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_nv_cmd,
  input  var  nvsp_op_e    i_nv_op,
  output logic [7:0]       o_array_rdata,
  output logic             o_nv_done
);
  int   left;
  logic busy;
  logic run;
  // stored cells hold a fixed pattern, locked or not
  assign o_array_rdata = i_addr[7:0] ^ 8'h3c;
  // erase timer, frozen while suspended, dropped by abort
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      busy <= 1'b0;
      run <= 1'b0;
      left <= 0;
      o_nv_done <= 1'b0;
    end else begin
      o_nv_done <= 1'b0;
      if (i_nv_cmd) begin
        case (i_nv_op)
          OP_ERASE: begin
            busy <= 1'b1;
            run <= 1'b1;
            left <= P_ERASE_CYCLES;
          end
          OP_SUSPEND: run <= 1'b0;
          OP_RESUME: run <= busy;
          OP_ABORT: begin
            busy <= 1'b0;
            run <= 1'b0;
          end
          default: ;
        endcase
      end else if (run) begin
        left <= left - 1;
        if (left == 1) begin
          o_nv_done <= 1'b1;
          busy <= 1'b0;
          run <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/test_nv_sector_protect_and_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_nv_sector_protect_and_select;
  import nvsp_pkg::*;
  localparam int RST_N = 8;
  localparam logic [15:0] FL = {CTRL_PAGE, FLASH_LOCK_OFS};
  localparam logic [15:0] EL = {CTRL_PAGE, EE_LOCK_OFS};
  logic        i_clk, i_reset, i_ce, i_wr, i_rd, i_nv_done, i_tap_lock_load, i_tap_secure;
  logic        i_batt_pin_is_output, i_supply_below_batt, i_batt_feeds_sram;
  logic        o_rdata_valid, o_nv_cmd, o_nv_to_ee, o_erase_suspended, o_cmd_idle;
  logic        o_sram_select, o_batt_active, o_batt_active_oe, lee;
  logic [15:0] i_addr, o_nv_addr;
  logic [7:0]  i_page, i_wdata, i_array_rdata, o_rdata, o_nv_wdata, o_nv_sector_mask;
  logic [7:0]  i_tap_flash_lock, lmask;
  logic [3:0]  i_tap_ee_lock;
  logic [2:0]  lop;
  nvsp_op_e    o_nv_op;
  int          mismatches, comparisons;
  int          ncmd = 0;

  nvsp_top #(.P_RESET_CYCLES(RST_N)) dut_u (
    .i_clk, .i_reset, .i_ce, .i_addr, .i_page, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_rdata_valid, .i_array_rdata, .i_nv_done, .o_nv_cmd, .o_nv_op, .o_nv_addr,
    .o_nv_wdata, .o_nv_to_ee, .o_nv_sector_mask, .o_erase_suspended, .o_cmd_idle,
    .i_tap_lock_load, .i_tap_flash_lock, .i_tap_ee_lock, .i_tap_secure, .o_sram_select,
    .i_batt_pin_is_output, .i_supply_below_batt, .i_batt_feeds_sram, .o_batt_active,
    .o_batt_active_oe);
  nvsp_engine_model eng_u (.i_clk, .i_reset, .i_addr, .i_nv_cmd(o_nv_cmd),
    .i_nv_op(o_nv_op), .o_array_rdata(i_array_rdata), .o_nv_done(i_nv_done));

  // 125 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // record every command pulse to the engine
  always @(posedge i_clk) begin
    if (o_nv_cmd === 1'b1) begin
      ncmd <= ncmd + 1;
      lop <= o_nv_op;
      lmask <= o_nv_sector_mask;
      lee <= o_nv_to_ee;
    end
  end

  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] p, input logic [7:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_page = p;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [7:0] p, input logic [7:0] e);
    int n;
    @(negedge i_clk);
    i_addr = a;
    i_page = p;
    i_rd = 1'b1;
    @(negedge i_clk);
    i_rd = 1'b0;
    n = 0;
    while (o_rdata_valid !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    chk(o_rdata, e);
    if (o_rdata_valid !== 1'b1) begin
      mismatches++;
      stop_test();
    end
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (o_cmd_idle !== 1'b1 && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk(8'(o_cmd_idle), 8'h01);
    if (o_cmd_idle !== 1'b1) stop_test();
  endtask
  task automatic unl(input logic [15:0] a, input logic [7:0] p);
    wr(a, p, CMD_UNLOCK1);
    wr(a, p, CMD_UNLOCK2);
  endtask
  task automatic ers(input logic [7:0] p);
    unl(16'h8000, p);
    wr(16'h8000, p, CMD_ERASE);
    unl(16'h8000, p);
    wr(16'h8000, p, CMD_CONFIRM);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] p, input logic [7:0] d);
    unl(a, p);
    wr(a, p, CMD_PROGRAM);
    wr(a, p, d);
  endtask
  task automatic cmd_chk(input int n0, input int n, input logic [2:0] op,
                         input logic [7:0] m, input logic ee);
    repeat (2) @(negedge i_clk);
    chk(8'(ncmd - n0), 8'(n));
    if (n > 0) begin
      chk(8'(lop), 8'(op));
      chk(lmask, m);
      chk(8'(lee), 8'(ee));
    end
  endtask

  // lock registers: reset value, load from test port, host writes ignored
  task automatic t_regs();
    rdc(FL, 8'h00, 8'h00);
    rdc(EL, 8'h00, 8'h00);
    @(negedge i_clk);
    i_tap_flash_lock = 8'ha5;
    i_tap_ee_lock = 4'h9;
    i_tap_secure = 1'b1;
    i_tap_lock_load = 1'b1;
    @(negedge i_clk);
    i_tap_lock_load = 1'b0;
    rdc(FL, 8'h00, 8'ha5);
    rdc(EL, 8'h00, 8'h89);
    wr(FL, 8'h00, 8'h00);
    wr(EL, 8'h00, 8'h7f);
    rdc(FL, 8'h00, 8'ha5);
    rdc(EL, 8'h00, 8'h89);
    rdc({CTRL_PAGE, 8'hc4}, 8'h00, 8'h00);
  endtask
  // locked sectors drop commands, unlocked ones in the same array do not
  task automatic t_locks();
    int n0;
    n0 = ncmd;
    ers(8'h00);
    cmd_chk(n0, 0, OP_NONE, 8'h00, 1'b0);
    chk(8'(o_cmd_idle), 8'h01);
    rdc(16'h8010, 8'h00, 8'h2c);
    prog(16'h0000, 8'h00, 8'h5a);
    cmd_chk(n0, 0, OP_NONE, 8'h00, 1'b0);
    prog(16'h2000, 8'h00, 8'h5a);
    cmd_chk(n0, 1, OP_PROGRAM, 8'h02, 1'b1);
    chk(o_nv_addr[15:8], 8'h20);
    chk(o_nv_wdata, 8'h5a);
  endtask
  // erase, suspend, refused program, read, resume, finish
  task automatic t_erase();
    int n0;
    n0 = ncmd;
    ers(8'h01);
    cmd_chk(n0, 1, OP_ERASE, 8'h02, 1'b0);
    wr(16'h8000, 8'h01, CMD_SUSPEND);
    cmd_chk(n0, 2, OP_SUSPEND, 8'h02, 1'b0);
    chk(8'(o_erase_suspended), 8'h01);
    prog(16'h8000, 8'h03, 8'h11);
    cmd_chk(n0, 2, OP_SUSPEND, 8'h02, 1'b0);
    rdc(16'h8000, 8'h03, 8'h3c);
    wr(16'h8000, 8'h01, CMD_RESUME);
    cmd_chk(n0, 3, OP_RESUME, 8'h02, 1'b0);
    wait_idle(100);
  endtask
  // resume with nothing suspended is dropped
  task automatic t_stray();
    int n0;
    n0 = ncmd;
    wr(16'h8000, 8'h01, CMD_RESUME);
    cmd_chk(n0, 0, OP_NONE, 8'h00, 1'b0);
    chk(8'(o_cmd_idle), 8'h01);
  endtask
  // reset command, single write then three writes
  task automatic t_reset();
    int n0;
    n0 = ncmd;
    wr(16'h8000, 8'h01, CMD_RESET);
    cmd_chk(n0, 1, OP_ABORT, 8'h02, 1'b0);
    wait_idle(RST_N + 4);
    unl(16'h8000, 8'h01);
    wr(16'h8000, 8'h01, CMD_RESET);
    cmd_chk(n0, 2, OP_ABORT, 8'h02, 1'b0);
    wait_idle(RST_N + 4);
  endtask
  // sram select over its two windows and their edges
  task automatic t_sram();
    logic [24:0] tv [6] = '{{16'hc7ff, 8'h09, 1'b1}, {16'hc800, 8'h00, 1'b0},
      {16'hd000, 8'h00, 1'b1}, {16'hd000, 8'h01, 1'b0}, {16'h8000, 8'h00, 1'b0},
      {16'hc000, 8'h05, 1'b1}};
    for (int i = 0; i < 6; i++) begin
      @(negedge i_clk);
      {i_addr, i_page} = tv[i][24:1];
      #2 chk(8'(o_sram_select), 8'(tv[i][0]));
    end
    wr(16'hc010, 8'h00, 8'h77);
    wr(16'hd010, 8'h01, 8'h66);
    rdc(16'hc010, 8'h00, 8'h77);
    rdc(16'hd010, 8'h00, 8'h77);
  endtask
  // every combination of the battery conditions
  task automatic t_batt();
    for (int i = 0; i < 8; i++) begin
      @(negedge i_clk);
      {i_batt_pin_is_output, i_supply_below_batt, i_batt_feeds_sram} = 3'(i);
      @(negedge i_clk);
      chk(8'(o_batt_active), 8'(i == 7));
      chk(8'(o_batt_active_oe), 8'(i[2]));
    end
  endtask

  initial begin
    {i_reset, i_ce, i_wr, i_rd, i_tap_lock_load, i_tap_secure} = 6'h30;
    {i_batt_pin_is_output, i_supply_below_batt, i_batt_feeds_sram} = 3'h0;
    {i_addr, i_page, i_wdata, i_tap_flash_lock, i_tap_ee_lock} = 44'h0;
    {mismatches, comparisons} = 64'h0;
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
    t_regs();
    t_locks();
    t_erase();
    t_stray();
    t_reset();
    t_sram();
    t_batt();
    stop_test();
  end
endmodule
bind nvsp_top nvsp_top_assertions #(.P_RESET_CYCLES(P_RESET_CYCLES)) chk_u (
  .i_clk, .i_reset, .i_ce, .i_rd, .o_rdata_valid, .o_nv_cmd, .o_nv_op, .o_nv_sector_mask,
  .o_erase_suspended, .o_cmd_idle, .i_batt_pin_is_output, .i_supply_below_batt,
  .i_batt_feeds_sram, .o_batt_active, .o_batt_active_oe);
`default_nettype wire
